/* File: rtl/psled_pkg.sv */
// Package of constants and carrier types for the status lamp driver
package psled_pkg;

  // ==================================================================
  // Timing
  // ==================================================================
  // System clock period in ns
  localparam int CLK_PERIOD_NS = 20;
  // Fault blink half period in ms
  localparam int FAULT_HALF_MS = 250;
  // Fault blink half period in clock cycles
  localparam int FAULT_HALF_CYC = (FAULT_HALF_MS * 1000000) / CLK_PERIOD_NS;
  // Activity flash pulse length in ms
  localparam int ACT_PULSE_MS = 50;
  // Activity flash pulse length in clock cycles
  localparam int ACT_PULSE_CYC = (ACT_PULSE_MS * 1000000) / CLK_PERIOD_NS;
  // Activity dark gap length in ms
  localparam int ACT_GAP_MS = 50;
  // Activity dark gap length in clock cycles
  localparam int ACT_GAP_CYC = (ACT_GAP_MS * 1000000) / CLK_PERIOD_NS;

  // ==================================================================
  // Lamp field positions in the mirror word
  // ==================================================================
  localparam int MIR_EXEC_BIT  = 0;
  localparam int MIR_IO_BIT    = 1;
  localparam int MIR_PROC_BIT  = 2;
  localparam int MIR_FIELD_BIT = 3;
  localparam int MIR_WIDTH     = 4;
  // Mirror value after reset, all dark
  localparam logic [3:0] MIR_RESET = 4'h0;

  // ==================================================================
  // Types
  // ==================================================================
  // Controller execution state
  typedef enum logic [1:0] {
    PSLED_ST_IDLE    = 2'b00,
    PSLED_ST_RUN     = 2'b01,
    PSLED_ST_STOP    = 2'b10,
    PSLED_ST_SWHALT  = 2'b11
  } psled_run_e;

  // Activity flasher state
  typedef enum logic [1:0] {
    PSLED_ACT_DARK = 2'b00,
    PSLED_ACT_LIT  = 2'b01,
    PSLED_ACT_GAP  = 2'b10
  } psled_act_e;

  // Fault and configuration conditions
  typedef struct packed {
    logic cell_absent;
    logic cell_flat;
    logic cell_reversed;
    logic cell_wrong_type;
    logic app_invalid;
    logic proc_error;
    logic io_error;
    logic rack_bus_error;
    logic card_cell_fault;
  } psled_fault_s;

  // Lamp outputs
  typedef struct packed {
    logic cell_backup_fault_lamp;
    logic exec_lamp;
    logic console_port_lamp;
    logic io_fault_lamp;
    logic fieldbus_link_lamp;
    logic proc_fault_lamp;
  } psled_lamps_s;

endpackage

/* File: rtl/psled_driver.sv */
// Status lamp driver for the controller processor card
// Notes on behaviour
// - Backup-cell lamp steady on fault, never flashes
// - Execution lamp steady running, flashes when stopped
// - Execution lamp dark: no application or error
// - Console lamp flashes with traffic, dark idle
// - Fieldbus lamp flashes with traffic, dark idle
// - I/O lamp steady on I/O or configuration error (io_error); flashes instead on rack bus error
// - Rack bus error flashes I/O, processor together
// - Processor lamp steady error, flashes lesser faults
// - Execution, I/O, processor, fieldbus mirrored to host
// - Autostart cartridge runs controller after power-up
`timescale 1ns/10ps
`default_nettype none

module psled_driver #(
  parameter int FAULT_HALF_CYC = psled_pkg::FAULT_HALF_CYC,
  parameter int ACT_PULSE_CYC  = psled_pkg::ACT_PULSE_CYC,
  parameter int ACT_GAP_CYC    = psled_pkg::ACT_GAP_CYC
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Fault conditions
  input  wire psled_pkg::psled_fault_s fault_i,
  // Execution control
  input  wire logic                   card_present_i,
  input  wire logic                   card_autostart_i,
  input  wire logic                   run_req_i,
  input  wire logic                   stop_req_i,
  input  wire logic                   sw_halt_i,
  // Traffic events, one pulse per transfer
  input  wire logic                   console_event_i,
  input  wire logic                   console_link_up_i,
  input  wire logic                   fieldbus_event_i,
  input  wire logic                   fieldbus_link_up_i,
  // Lamps
  output logic                        cell_backup_fault_lamp_o,
  output logic                        exec_lamp_o,
  output logic                        console_port_lamp_o,
  output logic                        io_fault_lamp_o,
  output logic                        fieldbus_link_lamp_o,
  output logic                        proc_fault_lamp_o,
  // Host mirror of lamp states
  output logic [psled_pkg::MIR_WIDTH-1:0] host_mirror_o,
  // Execution state seen by host
  output logic                        running_o
);

  // ==================================================================
  // Declarations
  // ==================================================================
  localparam int FW = (FAULT_HALF_CYC > 1) ? $clog2(FAULT_HALF_CYC) : 1;
  localparam int AW = $clog2(((ACT_PULSE_CYC > ACT_GAP_CYC) ? ACT_PULSE_CYC : ACT_GAP_CYC) + 1);

  logic [FW-1:0]         blink_cnt_r;   // Fault blink divider
  logic                  blink_r;       // Slow blink phase
  psled_pkg::psled_run_e run_r;         // Execution state
  logic                  boot_done_r;   // Power-up decision taken
  psled_pkg::psled_act_e con_st_r;      // Console flasher state
  logic [AW-1:0]         con_cnt_r;     // Console flasher timer
  psled_pkg::psled_act_e fb_st_r;       // Fieldbus flasher state
  logic [AW-1:0]         fb_cnt_r;      // Fieldbus flasher timer
  psled_pkg::psled_lamps_s lamps_nxt;   // Next lamp pattern
  logic                  cell_fault;    // Any backup-cell fault
  logic                  not_ready;     // No usable application or error
  logic [AW+1:0]         con_step;      // Console flasher next state and timer
  logic [AW+1:0]         fb_step;       // Fieldbus flasher next state and timer

  // Activity flasher step: event lights, timer lights then gaps
  function automatic logic [AW+1:0] act_step(input psled_pkg::psled_act_e st,
                                             input logic [AW-1:0] cnt,
                                             input logic link_up,
                                             input logic evt);
    psled_pkg::psled_act_e ns;
    logic [AW-1:0]         nc;
    ns = st;
    nc = cnt;
    if (!link_up) begin
      // Inactive link stays dark
      ns = psled_pkg::PSLED_ACT_DARK;
      nc = '0;
    end else begin
      case (st)
        psled_pkg::PSLED_ACT_DARK: begin
          // Traffic starts a flash
          if (evt) begin
            ns = psled_pkg::PSLED_ACT_LIT;
            nc = AW'(ACT_PULSE_CYC - 1);
          end
        end
        psled_pkg::PSLED_ACT_LIT: begin
          // Hold lit, then a dark gap
          if (cnt == '0) begin
            ns = psled_pkg::PSLED_ACT_GAP;
            nc = AW'(ACT_GAP_CYC - 1);
          end else begin
            nc = cnt - 1'b1;
          end
        end
        default: begin
          // Gap ends; more traffic flashes again at once
          if (cnt == '0) begin
            ns = evt ? psled_pkg::PSLED_ACT_LIT : psled_pkg::PSLED_ACT_DARK;
            nc = evt ? AW'(ACT_PULSE_CYC - 1) : '0;
          end else begin
            nc = cnt - 1'b1;
          end
        end
      endcase
    end
    return {ns, nc};
  endfunction

  assign cell_fault = fault_i.cell_absent | fault_i.cell_flat |
                      fault_i.cell_reversed | fault_i.cell_wrong_type;
  assign not_ready  = fault_i.app_invalid | fault_i.proc_error;
  // Next flasher steps, split apart again in the flasher registers
  assign con_step   = act_step(con_st_r, con_cnt_r, console_link_up_i, console_event_i);
  assign fb_step    = act_step(fb_st_r, fb_cnt_r, fieldbus_link_up_i, fieldbus_event_i);

  // ==================================================================
  // Fault blink timebase
  // ==================================================================
  // Fixed slow blink
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == FW'(FAULT_HALF_CYC - 1)) begin
      blink_cnt_r <= '0;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 1'b1;
    end
  end

  // ==================================================================
  // Execution state
  // ==================================================================
  // Autostart after power-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r       <= psled_pkg::PSLED_ST_IDLE;
      boot_done_r <= 1'b0;
    end else begin
      boot_done_r <= 1'b1;
      if (not_ready) begin
        // No application or hard error: not executing
        run_r <= psled_pkg::PSLED_ST_IDLE;
      end else if (sw_halt_i) begin
        run_r <= psled_pkg::PSLED_ST_SWHALT;
      end else if (!boot_done_r) begin
        // First cycle after reset: autostart decides
        run_r <= (card_present_i && card_autostart_i) ?
                 psled_pkg::PSLED_ST_RUN : psled_pkg::PSLED_ST_STOP;
      end else if (stop_req_i) begin
        run_r <= psled_pkg::PSLED_ST_STOP;
      end else if (run_req_i) begin
        run_r <= psled_pkg::PSLED_ST_RUN;
      end else if (run_r == psled_pkg::PSLED_ST_IDLE) begin
        // Fault cleared: wait stopped
        run_r <= psled_pkg::PSLED_ST_STOP;
      end
    end
  end

  // ==================================================================
  // Activity flashers
  // ==================================================================
  // Console traffic flasher
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      con_st_r  <= psled_pkg::PSLED_ACT_DARK;
      con_cnt_r <= '0;
    end else begin
      con_st_r  <= psled_pkg::psled_act_e'(con_step[AW+1:AW]);
      con_cnt_r <= con_step[AW-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fb_st_r  <= psled_pkg::PSLED_ACT_DARK;
      fb_cnt_r <= '0;
    end else begin
      fb_st_r  <= psled_pkg::psled_act_e'(fb_step[AW+1:AW]);
      fb_cnt_r <= fb_step[AW-1:0];
    end
  end

  // ==================================================================
  // Lamp pattern
  // ==================================================================
  always_comb begin
    lamps_nxt.cell_backup_fault_lamp = cell_fault;
    case (run_r)
      psled_pkg::PSLED_ST_RUN:    lamps_nxt.exec_lamp = 1'b1;
      psled_pkg::PSLED_ST_STOP,
      psled_pkg::PSLED_ST_SWHALT: lamps_nxt.exec_lamp = blink_r;
      default:                    lamps_nxt.exec_lamp = 1'b0;
    endcase
    if (not_ready) begin
      lamps_nxt.exec_lamp = 1'b0;
    end
    lamps_nxt.console_port_lamp  = (con_st_r == psled_pkg::PSLED_ACT_LIT);
    lamps_nxt.fieldbus_link_lamp = (fb_st_r == psled_pkg::PSLED_ACT_LIT);
    if (fault_i.rack_bus_error) begin
      lamps_nxt.io_fault_lamp = blink_r;
    end else begin
      lamps_nxt.io_fault_lamp = fault_i.io_error;
    end
    if (fault_i.proc_error) begin
      lamps_nxt.proc_fault_lamp = 1'b1;
    end else if (fault_i.app_invalid || run_r == psled_pkg::PSLED_ST_SWHALT ||
                 fault_i.card_cell_fault || fault_i.rack_bus_error) begin
      lamps_nxt.proc_fault_lamp = blink_r;
    end else begin
      lamps_nxt.proc_fault_lamp = 1'b0;
    end
  end

  // ==================================================================
  // Output registers
  // ==================================================================
  // Registered lamps, dark in reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cell_backup_fault_lamp_o <= 1'b0;
      exec_lamp_o              <= 1'b0;
      console_port_lamp_o      <= 1'b0;
      io_fault_lamp_o          <= 1'b0;
      fieldbus_link_lamp_o     <= 1'b0;
      proc_fault_lamp_o        <= 1'b0;
      running_o                <= 1'b0;
    end else begin
      cell_backup_fault_lamp_o <= lamps_nxt.cell_backup_fault_lamp;
      exec_lamp_o              <= lamps_nxt.exec_lamp;
      console_port_lamp_o      <= lamps_nxt.console_port_lamp;
      io_fault_lamp_o          <= lamps_nxt.io_fault_lamp;
      fieldbus_link_lamp_o     <= lamps_nxt.fieldbus_link_lamp;
      proc_fault_lamp_o        <= lamps_nxt.proc_fault_lamp;
      running_o                <= (run_r == psled_pkg::PSLED_ST_RUN);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_mirror_o <= psled_pkg::MIR_RESET;
    end else begin
      host_mirror_o[psled_pkg::MIR_EXEC_BIT]  <= lamps_nxt.exec_lamp;
      host_mirror_o[psled_pkg::MIR_IO_BIT]    <= lamps_nxt.io_fault_lamp;
      host_mirror_o[psled_pkg::MIR_PROC_BIT]  <= lamps_nxt.proc_fault_lamp;
      host_mirror_o[psled_pkg::MIR_FIELD_BIT] <= lamps_nxt.fieldbus_link_lamp;
    end
  end

endmodule
`default_nettype wire

/* File: test/psled_chk.sv */
// Checker of lamp timing relations for the status lamp driver
`timescale 1ns/10ps
`default_nettype none
module psled_chk #(
  parameter int FAULT_HALF_CYC = psled_pkg::FAULT_HALF_CYC,
  parameter int ACT_PULSE_CYC  = psled_pkg::ACT_PULSE_CYC,
  parameter int ACT_GAP_CYC    = psled_pkg::ACT_GAP_CYC
) (
  // Clock, reset and causes
  input wire logic                            clk_i,
  input wire logic                            rst_i,
  input wire psled_pkg::psled_fault_s         fault_i,
  input wire logic                            console_link_up_i,
  // Lamps and host mirror
  input wire logic                            cell_backup_fault_lamp_o,
  input wire logic                            exec_lamp_o,
  input wire logic                            console_port_lamp_o,
  input wire logic                            io_fault_lamp_o,
  input wire logic                            fieldbus_link_lamp_o,
  input wire logic                            proc_fault_lamp_o,
  input wire logic [psled_pkg::MIR_WIDTH-1:0] host_mirror_o
);
  // ==========================================
  // Clocking and lit run counter
  // ==========================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles the console lamp has been lit in a row
  int lit_cnt_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      lit_cnt_r <= 0;
    else
      lit_cnt_r <= console_port_lamp_o ? lit_cnt_r + 1 : 0;
  end
  // ==========================================
  // Assertions
  // ==========================================
  cell_lamp_a: assert property (
    !$past(rst_i) |-> cell_backup_fault_lamp_o == $past(|fault_i[8:5]))
    else $error("cell lamp wrong");
  io_steady_a: assert property (
    !$past(rst_i) && !$past(fault_i.rack_bus_error) |-> io_fault_lamp_o == $past(fault_i.io_error))
    else $error("io lamp wrong");
  rack_sync_a: assert property (
    !$past(rst_i) && $past(fault_i.rack_bus_error) && !$past(fault_i.proc_error)
    |-> io_fault_lamp_o == proc_fault_lamp_o) else $error("rack blink not together");
  proc_steady_a: assert property (
    !$past(rst_i) && $past(fault_i.proc_error) |-> proc_fault_lamp_o)
    else $error("proc lamp not steady");
  exec_dark_a: assert property (
    (fault_i.app_invalid || fault_i.proc_error) [*3] |-> !exec_lamp_o)
    else $error("exec lamp lit");
  mirror_a: assert property (
    host_mirror_o == {fieldbus_link_lamp_o, proc_fault_lamp_o, io_fault_lamp_o, exec_lamp_o})
    else $error("mirror differs");
  con_dark_a: assert property (
    !console_link_up_i [*2] |=> !console_port_lamp_o) else $error("console lamp lit");
  con_pulse_a: assert property (
    $fell(console_port_lamp_o) && console_link_up_i && $past(console_link_up_i) &&
    $past(console_link_up_i, 2)
    |-> lit_cnt_r == ACT_PULSE_CYC) else $error("console pulse length");
  // Main scenarios reached
  cover property ($rose(console_port_lamp_o));
  cover property (fault_i.rack_bus_error && io_fault_lamp_o && proc_fault_lamp_o);
  cover property ($fell(exec_lamp_o) ##[1:20] exec_lamp_o);
endmodule
bind psled_driver psled_chk #(.FAULT_HALF_CYC(FAULT_HALF_CYC), .ACT_PULSE_CYC(ACT_PULSE_CYC),
  .ACT_GAP_CYC(ACT_GAP_CYC)) u_psled_chk (
  .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault_i), .console_link_up_i(console_link_up_i),
  .cell_backup_fault_lamp_o(cell_backup_fault_lamp_o), .exec_lamp_o(exec_lamp_o),
  .console_port_lamp_o(console_port_lamp_o), .io_fault_lamp_o(io_fault_lamp_o),
  .fieldbus_link_lamp_o(fieldbus_link_lamp_o), .proc_fault_lamp_o(proc_fault_lamp_o),
  .host_mirror_o(host_mirror_o));
`default_nettype wire

/* File: test/psled_host_view.sv */
// Host status utility model: shows the mirrored lamp word
`timescale 1ns/10ps
`default_nettype none
module psled_host_view (
  // Clock
  input  wire logic       clk_i,
  // Mirror word from the card
  input  wire logic [3:0] host_mirror_i,
  // Lamp states shown to the user
  output logic [3:0]      shown_o
);
  always_ff @(posedge clk_i) shown_o <= host_mirror_i;
endmodule
`default_nettype wire

/* File: test/psled_driver_bench.sv */
// Self-checking bench for the status lamp driver
`timescale 1ns/10ps
`default_nettype none
module psled_driver_bench;
  // Stimulus, changed at the rising edge only
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  psled_pkg::psled_fault_s fault_i = '0;
  logic card_present_i = 1'b1, card_autostart_i = 1'b1, run_req_i = 1'b0, stop_req_i = 1'b0;
  logic sw_halt_i = 1'b0, console_event_i = 1'b0, console_link_up_i = 1'b0;
  logic fieldbus_event_i = 1'b0, fieldbus_link_up_i = 1'b0;
  // Lamps: 5 cell, 4 exec, 3 console, 2 io, 1 fieldbus, 0 proc
  logic cell_backup_fault_lamp_o, exec_lamp_o, console_port_lamp_o, io_fault_lamp_o;
  logic fieldbus_link_lamp_o, proc_fault_lamp_o, running_o;
  logic [3:0] host_mirror_o, shown;
  logic [5:0] lamps;
  int miscompares = 0, tests_run = 0, ones;
  assign lamps = {cell_backup_fault_lamp_o, exec_lamp_o, console_port_lamp_o, io_fault_lamp_o,
                  fieldbus_link_lamp_o, proc_fault_lamp_o};
  always #10 clk_i = ~clk_i;
  // Short counts: blink half 8, pulse 3, gap 2
  psled_driver #(.FAULT_HALF_CYC(8), .ACT_PULSE_CYC(3), .ACT_GAP_CYC(2)) u_psled_driver (
    .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault_i),
    .card_present_i(card_present_i), .card_autostart_i(card_autostart_i),
    .run_req_i(run_req_i), .stop_req_i(stop_req_i), .sw_halt_i(sw_halt_i),
    .console_event_i(console_event_i), .console_link_up_i(console_link_up_i),
    .fieldbus_event_i(fieldbus_event_i), .fieldbus_link_up_i(fieldbus_link_up_i),
    .cell_backup_fault_lamp_o(cell_backup_fault_lamp_o), .exec_lamp_o(exec_lamp_o),
    .console_port_lamp_o(console_port_lamp_o), .io_fault_lamp_o(io_fault_lamp_o),
    .fieldbus_link_lamp_o(fieldbus_link_lamp_o), .proc_fault_lamp_o(proc_fault_lamp_o),
    .host_mirror_o(host_mirror_o), .running_o(running_o));
  psled_host_view u_psled_host_view (.clk_i(clk_i), .host_mirror_i(host_mirror_o), .shown_o(shown));
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Count lit samples of one lamp
  task automatic watch(int idx, int n);
    ones = 0;
    repeat (n) begin
      @(negedge clk_i);
      ones += (lamps[idx] === 1'b1);
    end
  endtask
  task automatic steady(string nm, int idx, bit on);
    watch(idx, 20);
    chk(nm, on ? 8'h14 : 8'h0, 8'(ones));
  endtask
  // Half period 8 over 40 cycles lights 16 to 24
  task automatic flash(string nm, int idx);
    watch(idx, 40);
    chk(nm, 8'h1, 8'(ones >= 16 && ones <= 24));
  endtask
  task automatic setf(logic [8:0] f, int n);
    @(posedge clk_i) fault_i <= f;
    cyc(n);
  endtask
  task automatic link(bit fb, logic ev, logic up);
    @(posedge clk_i);
    if (fb) begin
      fieldbus_event_i <= ev;
      fieldbus_link_up_i <= up;
    end else begin
      console_event_i <= ev;
      console_link_up_i <= up;
    end
  endtask
  task automatic fin(string s);
    $display("%s done, miscompares %0d", s, miscompares);
  endtask
  task automatic test_done;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_power;
    cyc(7);
    @(negedge clk_i) chk("lamps in reset", 8'h0, 8'(lamps));
    @(posedge clk_i) rst_i <= 1'b0;
    cyc(4);
    steady("exec autostart", 4, 1);
    chk("running", 8'h1, 8'(running_o));
    fin("t_power");
  endtask
  task automatic t_cell;
    for (int b = 5; b <= 8; b++) begin
      setf(9'h1 << b, 2);
      steady("cell lamp on", 5, 1);
      setf(9'h0, 2);
      steady("cell lamp off", 5, 0);
    end
    fin("t_cell");
  endtask
  task automatic t_io;
    setf(9'h004, 3);
    steady("io lamp", 2, 1);
    chk("host view", 8'h3, 8'(shown));
    setf(9'h0, 2);
    steady("io lamp off", 2, 0);
    fin("t_io");
  endtask
  task automatic t_rack;
    setf(9'h002, 2);
    flash("io rack", 2);
    flash("proc rack", 0);
    setf(9'h0, 2);
    fin("t_rack");
  endtask
  task automatic t_proc;
    setf(9'h008, 3);
    steady("proc error", 0, 1);
    steady("exec on error", 4, 0);
    setf(9'h010, 3);
    flash("proc no app", 0);
    steady("exec no app", 4, 0);
    setf(9'h001, 2);
    flash("proc card cell", 0);
    setf(9'h0, 1);
    @(posedge clk_i) sw_halt_i <= 1'b1;
    cyc(3);
    flash("proc halt", 0);
    flash("exec halt", 4);
    @(posedge clk_i) sw_halt_i <= 1'b0;
    fin("t_proc");
  endtask
  task automatic t_exec;
    @(posedge clk_i) stop_req_i <= 1'b1;
    @(posedge clk_i) stop_req_i <= 1'b0;
    cyc(2);
    flash("exec stopped", 4);
    @(posedge clk_i) run_req_i <= 1'b1;
    @(posedge clk_i) run_req_i <= 1'b0;
    cyc(2);
    steady("exec running", 4, 1);
    fin("t_exec");
  endtask
  task automatic t_act(bit fb, int idx);
    link(fb, 1'b1, 1'b0);
    steady("link down dark", idx, 0);
    link(fb, 1'b0, 1'b1);
    link(fb, 1'b1, 1'b1);
    link(fb, 1'b0, 1'b1);
    watch(idx, 12);
    chk("single flash", 8'h3, 8'(ones));
    link(fb, 1'b1, 1'b1);
    cyc(5);
    watch(idx, 30);
    chk("busy flash", 8'h12, 8'(ones));
    link(fb, 1'b0, 1'b0);
    cyc(8);
    fin("t_act");
  endtask
  task automatic t_reset;
    setf(9'h104, 3);
    @(posedge clk_i) rst_i <= 1'b1;
    @(negedge clk_i) chk("lamps mid reset", 8'h0, 8'(lamps));
    setf(9'h0, 2);
    @(posedge clk_i) rst_i <= 1'b0;
    cyc(4);
    steady("exec restart", 4, 1);
    fin("t_reset");
  endtask
  // Cartridge missing, then present without autostart: both wait stopped
  task automatic t_noauto;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) begin
        rst_i <= 1'b1;
        card_present_i <= 1'(k);
        card_autostart_i <= 1'(1 - k);
      end
      cyc(2);
      @(posedge clk_i) rst_i <= 1'b0;
      cyc(4);
      flash("exec no autostart", 4);
      chk("not running", 8'h0, 8'(running_o));
    end
    fin("t_noauto");
  endtask
  // Main sequence
  initial begin
    t_power;
    t_cell;
    t_io;
    t_rack;
    t_proc;
    t_exec;
    t_act(1'b0, 3);
    t_act(1'b1, 1);
    t_reset;
    t_noauto;
    test_done;
  end
  // Hang guard, nearly three times the expected run
  initial begin
    #50us;
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire
